// ===== hdl/dofc_map.vh
// Purpose: constants shared by the decimal operand format codec
// Assumes: included by bare name from hdl/
// Notes:   byte codes are 7-bit; the parity bit is kept apart
`ifndef DOFC_MAP_VH
`define DOFC_MAP_VH

// conversion direction
`define DOFC_OP_PACK        1'b0
`define DOFC_OP_UNPACK      1'b1

// character-form sign representation selector
`define DOFC_REP_EMB_TRAIL  3'h0
`define DOFC_REP_SEP_TRAIL  3'h1
`define DOFC_REP_EMB_LEAD   3'h2
`define DOFC_REP_SEP_LEAD   3'h3
`define DOFC_REP_UNSIGNED   3'h4

// packed nibble codes
`define DOFC_NIB_MAX_DIGIT  4'h9
`define DOFC_NIB_PLUS       4'hc
`define DOFC_NIB_MINUS      4'hd
`define DOFC_NIB_UNSIGNED   4'hf

// character codes
`define DOFC_ZONE_DIGIT     4'h3
`define DOFC_CHR_PLUS       7'h2b
`define DOFC_CHR_MINUS      7'h2d
`define DOFC_CHR_DIG_LO     7'h30
`define DOFC_CHR_DIG_HI     7'h39
`define DOFC_EMB_POS_BASE   7'h40
`define DOFC_EMB_POS_HI     7'h49
`define DOFC_EMB_NEG_BASE   7'h49
`define DOFC_EMB_NEG_HI     7'h52
`define DOFC_EMB_POS_ZERO   7'h7b
`define DOFC_EMB_NEG_ZERO   7'h7d

// field limits, in nibbles (packed) or bytes (character)
`define DOFC_PK_MAX_LEN     6'h20
`define DOFC_CH_MAX_LEN     6'h20

// error codes
`define DOFC_ERR_NONE       3'h0
`define DOFC_ERR_ILLEGAL    3'h2
`define DOFC_ERR_OVERFLOW   3'h3
`define DOFC_ERR_DESCR      3'h4

// operand buffers
`define DOFC_BUF_WORDS      16

`endif

// ===== hdl/dofc_pk_dec.v
// Purpose: classify one packed nibble as digit or sign
// Assumes: purely combinational
// Notes:   sign is taken from bit 0 so every code is accepted
`timescale 1ns/100ps
`default_nettype none
`include "dofc_map.vh"

module dofc_pk_dec (
   input  wire [3:0] nib,
   output wire       digit_bad,
   output wire       sign_neg
);

   assign digit_bad = (nib > `DOFC_NIB_MAX_DIGIT);
   // 1011/1101 negative, 1010/1100/1110 positive, 1111 plus
   assign sign_neg  = nib[0] & (nib != `DOFC_NIB_UNSIGNED);

endmodule // dofc_pk_dec

`default_nettype wire

// ===== hdl/dofc_ch_dec.v
// Purpose: decode one character-form byte as digit, sign or both
// Assumes: purely combinational; emb and sep never both high
// Notes:   plain digit bytes are also taken where a sign is embedded
`timescale 1ns/100ps
`default_nettype none
`include "dofc_map.vh"

module dofc_ch_dec (
   input  wire [7:0] chr,
   input  wire       emb,
   input  wire       sep,
   output reg  [3:0] digit,
   output reg        bad,
   output reg        neg
);

   reg [6:0] c;
   reg [6:0] t;

   always @* begin
      c     = chr[6:0];
      t     = 7'h00;
      digit = 4'h0;
      bad   = 1'b0;
      neg   = 1'b0;
      if (sep) begin
         neg = (c == `DOFC_CHR_MINUS);
         bad = (c != `DOFC_CHR_PLUS) && (c != `DOFC_CHR_MINUS);
      end else if (emb) begin
         if (c == `DOFC_EMB_POS_ZERO) begin
            digit = 4'h0;
         end else if (c == `DOFC_EMB_NEG_ZERO) begin
            neg = 1'b1;
         end else if (c > `DOFC_EMB_POS_BASE && c <= `DOFC_EMB_POS_HI) begin
            t     = c - `DOFC_EMB_POS_BASE;
            digit = t[3:0];
         end else if (c > `DOFC_EMB_NEG_BASE && c <= `DOFC_EMB_NEG_HI) begin
            t     = c - `DOFC_EMB_NEG_BASE;
            digit = t[3:0];
            neg   = 1'b1;
         end else if (c >= `DOFC_CHR_DIG_LO && c <= `DOFC_CHR_DIG_HI) begin
            digit = c[3:0];
         end else begin
            bad = 1'b1;
         end
      end else begin
         // zone is not checked, only the numeric half
         digit = c[3:0];
         bad   = (c[3:0] > `DOFC_NIB_MAX_DIGIT);
      end
   end

endmodule // dofc_ch_dec

`default_nettype wire

// ===== hdl/dofc_codec.v
// Purpose: convert decimal operands between packed and character form
// Assumes: datapath loads the source buffer, then pulses start
// Notes:   position 0 of each buffer is the rightmost nibble/byte
//
// Overview of operation
// - two 4-bit digits per byte, two bytes per word
// - packed field at most 31 digits plus sign
// - digits zero to nine are binary 0000-1001
// - nibbles 1010-1111 are never digit values
// - 1010/1100/1110 positive, 1011/1101 negative
// - sign 1111 is unsigned, handled as positive
// - accept all signs, emit 1100/1101, or 1111 when dst_uns is set
// - character digit byte, upper half is zone
// - lower half holds digit, codes 0x30-0x39
// - parity bit neither checked nor set
// - separate trailing sign byte is 53/55 octal
// - separate leading sign is leftmost byte
// - embedded trailing: sign in rightmost digit byte
// - embedded leading: sign in leftmost digit byte
// - embedded codes 101-111 positive, 112-122 negative
// - character field at most 32 bytes
// - 3-bit selector picks character sign representation
// - packed sign by bit 0, zone 0011 out
`timescale 1ns/100ps
`default_nettype none
`include "dofc_map.vh"

module dofc_codec (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        src_wr_en,
   input  wire [3:0]  src_wr_addr,
   input  wire [15:0] src_wr_data,
   input  wire [3:0]  dst_rd_addr,
   output reg  [15:0] dst_rd_data_ff,
   input  wire        start,
   input  wire        op,
   input  wire [5:0]  src_len,
   input  wire [5:0]  dst_len,
   input  wire [2:0]  src_rep,
   input  wire [2:0]  dst_rep,
   input  wire        dst_uns,
   output reg         busy_ff,
   output reg         done_ff,
   output reg  [2:0]  err_code_ff,
   output reg  [5:0]  err_pos_ff,
   output reg         res_neg_ff
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_SIGN = 2'h1;
   localparam [1:0] ST_DIGS = 2'h2;
   localparam [1:0] ST_FIN  = 2'h3;

   function is_sep;
      input [2:0] rep;
      begin
         is_sep = (rep == `DOFC_REP_SEP_TRAIL) ||
                  (rep == `DOFC_REP_SEP_LEAD);
      end
   endfunction

   function is_lead;
      input [2:0] rep;
      begin
         is_lead = (rep == `DOFC_REP_EMB_LEAD) ||
                   (rep == `DOFC_REP_SEP_LEAD);
      end
   endfunction

   // digit slots in a field: length less the sign position
   function [5:0] dig_count;
      input [5:0] len;
      input       is_char;
      input [2:0] rep;
      reg   [5:0] sub;
      begin
         sub = 6'h00;
         if (!is_char || is_sep(rep))
            sub = 6'h01;
         dig_count = (len > sub) ? (len - sub) : 6'h00;
      end
   endfunction

   // digit d carries the embedded sign at this end of the field
   function emb_here;
      input [2:0] rep;
      input [5:0] d;
      input [5:0] n;
      begin
         emb_here = ((rep == `DOFC_REP_EMB_TRAIL) && (d == 6'h00)) ||
                    ((rep == `DOFC_REP_EMB_LEAD) &&
                     (d == n - 6'h01));
      end
   endfunction

   function [7:0] emb_chr;
      input [3:0] dg;
      input       neg;
      reg   [6:0] c;
      begin
         if (dg == 4'h0)
            c = neg ? `DOFC_EMB_NEG_ZERO : `DOFC_EMB_POS_ZERO;
         else if (neg)
            c = `DOFC_EMB_NEG_BASE + {3'h0, dg};
         else
            c = `DOFC_EMB_POS_BASE + {3'h0, dg};
         emb_chr = {1'b0, c};
      end
   endfunction

   reg  [15:0] src_mem [0:`DOFC_BUF_WORDS-1];
   reg  [15:0] dst_mem [0:`DOFC_BUF_WORDS-1];

   reg  [1:0]  state_ff;
   reg  [5:0]  d_ff;
   reg         op_ff;
   reg  [5:0]  slen_ff;
   reg  [5:0]  dlen_ff;
   reg  [2:0]  srep_ff;
   reg  [2:0]  drep_ff;
   reg         duns_ff;
   reg  [5:0]  nsrc_ff;
   reg  [5:0]  ndst_ff;
   reg  [5:0]  nmax_ff;

   reg  [1:0]  nxt_state;
   reg  [5:0]  src_idx;
   reg         ch_emb;
   reg         ch_sep;
   reg         wr_act;
   reg         wr_byte;
   reg  [5:0]  wr_idx;
   reg  [7:0]  wr_val;
   reg  [3:0]  dg;
   reg         dg_bad;
   reg         ovf;

   wire        src_char = (op_ff == `DOFC_OP_PACK);
   wire        dst_char = (op_ff == `DOFC_OP_UNPACK);
   wire        have_dig = (d_ff < nsrc_ff);
   wire        dst_fit  = (d_ff < ndst_ff);
   wire [5:0]  nsrc_in  = dig_count(src_len, ~op, src_rep);
   wire [5:0]  ndst_in  = dig_count(dst_len, op, dst_rep);
   wire        last_dig = (d_ff == nmax_ff - 6'h01);

   // packed fields index by nibble, character fields by byte
   wire [3:0]  src_waddr = src_char ? src_idx[4:1] : src_idx[5:2];
   wire [15:0] src_word  = src_mem[src_waddr];
   wire [15:0] nib_sh    = src_word >> {src_idx[1:0], 2'b00};
   wire [3:0]  src_nib   = nib_sh[3:0];
   wire [7:0]  src_byte  = src_idx[0] ? src_word[15:8] : src_word[7:0];

   wire        pk_bad;
   wire        pk_neg;
   wire [3:0]  ch_dig;
   wire        ch_bad;
   wire        ch_neg;

   // descriptor check happens at start, on the same edge that clears the destination buffer
   wire        rep_bad  = (~op && (src_rep > `DOFC_REP_UNSIGNED)) ||
                          (op && (dst_rep > `DOFC_REP_UNSIGNED));
   wire        len_bad  = (op ? (src_len > `DOFC_PK_MAX_LEN)
                              : (src_len > `DOFC_CH_MAX_LEN)) ||
                          (op ? (dst_len > `DOFC_CH_MAX_LEN)
                              : (dst_len > `DOFC_PK_MAX_LEN));

   wire        sign_chk = src_char && (slen_ff != 6'h00) &&
                          (srep_ff != `DOFC_REP_UNSIGNED);
   wire        sign_neg = (slen_ff == 6'h00) ? 1'b0 :
                          src_char ? (sign_chk & ch_neg) : pk_neg;
   wire        err_free = (err_code_ff == `DOFC_ERR_NONE);

   dofc_pk_dec u_pk_dec (
      .nib       (src_nib),
      .digit_bad (pk_bad),
      .sign_neg  (pk_neg)
   );

   dofc_ch_dec u_ch_dec (
      .chr   (src_byte),
      .emb   (ch_emb),
      .sep   (ch_sep),
      .digit (ch_dig),
      .bad   (ch_bad),
      .neg   (ch_neg)
   );

   // source position: sign first, then digits upward from the LSD
   always @* begin
      src_idx = 6'h00;
      ch_emb  = 1'b0;
      ch_sep  = 1'b0;
      if (state_ff == ST_SIGN) begin
         if (src_char) begin
            if (is_lead(srep_ff))
               src_idx = slen_ff - 6'h01;
            ch_sep = is_sep(srep_ff);
            ch_emb = ~ch_sep && (srep_ff != `DOFC_REP_UNSIGNED);
         end
      end else if (src_char) begin
         src_idx = d_ff + {5'h00, srep_ff == `DOFC_REP_SEP_TRAIL};
         ch_emb  = emb_here(srep_ff, d_ff, nsrc_ff);
      end else begin
         src_idx = d_ff + 6'h01;
      end
   end

   // digit value, checks and destination write
   always @* begin
      dg      = 4'h0;
      dg_bad  = 1'b0;
      ovf     = 1'b0;
      wr_act  = 1'b0;
      wr_byte = dst_char;
      wr_idx  = 6'h00;
      wr_val  = 8'h00;
      if (have_dig) begin
         dg     = src_char ? ch_dig : src_nib;
         dg_bad = src_char ? ch_bad : pk_bad;
      end
      case (state_ff)
         ST_DIGS: begin
            wr_act = dst_fit;
            // a lost non-zero digit is an overflow
            ovf    = ~dst_fit && (dg != 4'h0);
            if (dst_char) begin
               wr_idx = d_ff + {5'h00, drep_ff == `DOFC_REP_SEP_TRAIL};
               if (emb_here(drep_ff, d_ff, ndst_ff))
                  wr_val = emb_chr(dg, res_neg_ff);
               else
                  wr_val = {`DOFC_ZONE_DIGIT, dg};
            end else begin
               wr_idx = d_ff + 6'h01;
               wr_val = {4'h0, dg};
            end
         end
         ST_FIN: begin
            if (dst_char) begin
               wr_act = is_sep(drep_ff) && (dlen_ff != 6'h00);
               if (is_lead(drep_ff))
                  wr_idx = dlen_ff - 6'h01;
               wr_val = {1'b0, res_neg_ff ? `DOFC_CHR_MINUS
                                          : `DOFC_CHR_PLUS};
            end else begin
               wr_act = (dlen_ff != 6'h00);
               if (duns_ff)
                  wr_val = {4'h0, `DOFC_NIB_UNSIGNED};
               else
                  wr_val = {4'h0, res_neg_ff ? `DOFC_NIB_MINUS
                                             : `DOFC_NIB_PLUS};
            end
         end
         default: begin
            wr_act = 1'b0;
         end
      endcase
   end

   always @* begin
      case (state_ff)
         ST_IDLE: nxt_state = (start && !rep_bad && !len_bad) ?
                              ST_SIGN : ST_IDLE;
         ST_SIGN: nxt_state = (nmax_ff == 6'h00) ? ST_FIN : ST_DIGS;
         ST_DIGS: nxt_state = last_dig ? ST_FIN : ST_DIGS;
         ST_FIN:  nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= ST_IDLE;
         d_ff        <= 6'h00;
         op_ff       <= `DOFC_OP_PACK;
         slen_ff     <= 6'h00;
         dlen_ff     <= 6'h00;
         srep_ff     <= `DOFC_REP_EMB_TRAIL;
         drep_ff     <= `DOFC_REP_EMB_TRAIL;
         duns_ff     <= 1'b0;
         nsrc_ff     <= 6'h00;
         ndst_ff     <= 6'h00;
         nmax_ff     <= 6'h00;
         busy_ff     <= 1'b0;
         done_ff     <= 1'b0;
         err_code_ff <= `DOFC_ERR_NONE;
         err_pos_ff  <= 6'h00;
         res_neg_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         done_ff  <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  op_ff       <= op;
                  slen_ff     <= src_len;
                  dlen_ff     <= dst_len;
                  srep_ff     <= src_rep;
                  drep_ff     <= dst_rep;
                  duns_ff     <= dst_uns;
                  nsrc_ff     <= nsrc_in;
                  ndst_ff     <= ndst_in;
                  nmax_ff     <= (nsrc_in > ndst_in) ? nsrc_in : ndst_in;
                  d_ff        <= 6'h00;
                  err_pos_ff  <= 6'h00;
                  res_neg_ff  <= 1'b0;
                  // bad descriptor: finish at once, nothing converted
                  busy_ff     <= ~(rep_bad | len_bad);
                  done_ff     <= rep_bad | len_bad;
                  err_code_ff <= (rep_bad | len_bad) ? `DOFC_ERR_DESCR
                                                     : `DOFC_ERR_NONE;
               end
            end
            ST_SIGN: begin
               res_neg_ff <= sign_neg;
               if (sign_chk && ch_bad) begin
                  err_code_ff <= `DOFC_ERR_ILLEGAL;
                  err_pos_ff  <= src_idx;
               end
            end
            ST_DIGS: begin
               d_ff <= d_ff + 6'h01;
               // only the first error is kept
               if (err_free && have_dig && dg_bad) begin
                  err_code_ff <= `DOFC_ERR_ILLEGAL;
                  err_pos_ff  <= src_idx;
               end else if (err_free && have_dig && ovf) begin
                  err_code_ff <= `DOFC_ERR_OVERFLOW;
                  err_pos_ff  <= src_idx;
               end
            end
            ST_FIN: begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end
            default: begin
               busy_ff <= 1'b0;
            end
         endcase
      end
   end

   // source buffer: data only, loaded while idle
   always @(posedge sys_clk) begin
      if (src_wr_en && !busy_ff)
         src_mem[src_wr_addr] <= src_wr_data;
   end

   integer i;

   // destination is cleared at start so untouched positions read zero
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `DOFC_BUF_WORDS; i = i + 1)
            dst_mem[i] <= 16'h0000;
      end else if (state_ff == ST_IDLE && start) begin
         for (i = 0; i < `DOFC_BUF_WORDS; i = i + 1)
            dst_mem[i] <= 16'h0000;
      end else if (wr_act) begin
         if (wr_byte) begin
            if (wr_idx[0])
               dst_mem[wr_idx[4:1]][15:8] <= wr_val;
            else
               dst_mem[wr_idx[4:1]][7:0] <= wr_val;
         end else begin
            case (wr_idx[1:0])
               2'h0: dst_mem[wr_idx[5:2]][3:0]   <= wr_val[3:0];
               2'h1: dst_mem[wr_idx[5:2]][7:4]   <= wr_val[3:0];
               2'h2: dst_mem[wr_idx[5:2]][11:8]  <= wr_val[3:0];
               default: dst_mem[wr_idx[5:2]][15:12] <= wr_val[3:0];
            endcase
         end
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         dst_rd_data_ff <= 16'h0000;
      else
         dst_rd_data_ff <= dst_mem[dst_rd_addr];
   end

endmodule // dofc_codec

`default_nettype wire

// ===== tb/dofc_codec_props.sv
// Purpose: handshake checks for the decimal operand format codec
// Assumes: bound to dofc_codec; start is a one-cycle pulse
// Notes:   data encodings are judged by the bench
`timescale 1ns/100ps
`default_nettype none
module dofc_codec_props (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       start,
   input wire logic       op,
   input wire logic [5:0] src_len,
   input wire logic [5:0] dst_len,
   input wire logic [2:0] src_rep,
   input wire logic [2:0] dst_rep,
   input wire logic       busy_ff,
   input wire logic       done_ff,
   input wire logic [2:0] err_code_ff,
   input wire logic       res_neg_ff
);
   wire take   = start && !busy_ff;
   wire len_ok = (src_len <= 6'h20) && (dst_len <= 6'h20);
   wire rep_ok = op ? (dst_rep <= 3'h4) : (src_rep <= 3'h4);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_LEN_LIMIT: assert property (
      take && !len_ok |=> done_ff && !busy_ff && err_code_ff == 3'h4)
      else $error("oversize field not refused");
   AST_REP_LIMIT: assert property (
      take && len_ok && !rep_ok |=> done_ff && err_code_ff == 3'h4)
      else $error("bad sign selector not refused");
   AST_GOOD_START: assert property (
      take && len_ok && rep_ok |=> busy_ff && !done_ff)
      else $error("legal start not taken");
   AST_RUN_BOUND: assert property (
      $rose(busy_ff) |-> ##[2:34] (done_ff && !busy_ff))
      else $error("conversion too long");
   AST_BUSY_END: assert property (
      $fell(busy_ff) |-> done_ff)
      else $error("busy fell without done");
   AST_DONE_ONE: assert property (
      done_ff && !start |=> !done_ff)
      else $error("done longer than one cycle");
   AST_ERR_HOLD: assert property (
      !busy_ff && !start |=> $stable(err_code_ff))
      else $error("error code moved between runs");
   AST_NEG_HOLD: assert property (
      !busy_ff && !start |=> $stable(res_neg_ff))
      else $error("sign moved while idle");
endmodule // dofc_codec_props
`default_nettype wire

// ===== tb/dofc_dp_model.sv
// Purpose: datapath side that loads the source buffer and starts a run
// Assumes: bench holds the descriptor steady while go is served
// Notes:   slow spaces the writes and scrambles the data between them
`timescale 1ns/100ps
`default_nettype none
module dofc_dp_model (
   input  wire logic         sys_clk,
   input  wire logic         go,
   input  wire logic         slow,
   input  wire logic [255:0] img,
   input  wire logic         done_ff,
   output var  logic         src_wr_en,
   output var  logic [3:0]   src_wr_addr,
   output var  logic [15:0]  src_wr_data,
   output var  logic         start,
   output var  logic         fin
);
   initial begin
      src_wr_en = 1'b0;
      src_wr_addr = 4'h0;
      src_wr_data = 16'h0000;
      start = 1'b0;
      fin = 1'b0;
   end
   always begin
      @(posedge sys_clk);
      if (go) begin
         for (int w = 0; w < 16; w++) begin
            #1;
            src_wr_en = 1'b1;
            src_wr_addr = w[3:0];
            src_wr_data = img[w*16 +: 16];
            @(posedge sys_clk);
            if (slow) begin
               #1;
               src_wr_en = 1'b0;
               src_wr_data = ~src_wr_data;
               @(posedge sys_clk);
            end
         end
         #1;
         src_wr_en = 1'b0;
         src_wr_data = ~src_wr_data;
         start = 1'b1;
         @(posedge sys_clk);
         #1;
         start = 1'b0;
         // done may already stand for a refused descriptor
         while (!done_ff) begin
            @(posedge sys_clk);
            #1;
         end
         fin = 1'b1;
         @(posedge sys_clk);
         #1;
         fin = 1'b0;
      end
   end
endmodule // dofc_dp_model
`default_nettype wire

// ===== tb/dofc_codec_bench.sv
// Purpose: self-checking bench for the decimal operand format codec
// Assumes: position 0 is the rightmost nibble or byte
// Notes:   every run in the main loop is followed by a full read of the result buffer
`timescale 1ns/100ps
`default_nettype none
module dofc_codec_bench;
   logic         sys_clk, rst_n, go, slow, op, dst_uns, fin;
   logic         src_wr_en, start, busy_ff, done_ff, res_neg_ff;
   logic [3:0]   dst_rd_addr, src_wr_addr;
   logic [5:0]   src_len, dst_len, err_pos_ff;
   logic [2:0]   src_rep, dst_rep, err_code_ff;
   logic [15:0]  src_wr_data, dst_rd_data_ff;
   logic [255:0] img;
   logic [31:0]  seed;
   logic [3:0]   dg [0:31];
   int           n, cyc, err_total, checked;

   dofc_codec i_dofc_codec (.sys_clk(sys_clk), .rst_n(rst_n),
      .src_wr_en(src_wr_en), .src_wr_addr(src_wr_addr),
      .src_wr_data(src_wr_data), .dst_rd_addr(dst_rd_addr),
      .dst_rd_data_ff(dst_rd_data_ff), .start(start), .op(op),
      .src_len(src_len), .dst_len(dst_len), .src_rep(src_rep),
      .dst_rep(dst_rep), .dst_uns(dst_uns), .busy_ff(busy_ff),
      .done_ff(done_ff), .err_code_ff(err_code_ff),
      .err_pos_ff(err_pos_ff), .res_neg_ff(res_neg_ff));
   dofc_dp_model i_dofc_dp_model (.sys_clk(sys_clk), .go(go),
      .slow(slow), .img(img), .done_ff(done_ff), .src_wr_en(src_wr_en),
      .src_wr_addr(src_wr_addr), .src_wr_data(src_wr_data),
      .start(start), .fin(fin));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   function automatic int chlen(input logic [2:0] rep);
      return n + ((rep == 3'h1 || rep == 3'h3) ? 1 : 0);
   endfunction
   function automatic logic [255:0] pk_img(input logic [3:0] sg);
      logic [255:0] r;
      r = 256'h0;
      r[3:0] = sg;
      for (int p = 1; p <= n; p++) r[p*4 +: 4] = dg[p-1];
      return r;
   endfunction
   function automatic logic [7:0] emb(input logic [3:0] d, input logic ng);
      if (d == 4'h0) return ng ? 8'h7d : 8'h7b;
      return (ng ? 8'h49 : 8'h40) + {4'h0, d};
   endfunction
   function automatic logic [255:0] ch_img(input logic [2:0] rep,
                                           input logic       ng);
      logic [255:0] r;
      int           d;
      r = 256'h0;
      for (int p = 0; p < 32; p++) begin
         d = (rep == 3'h1) ? p - 1 : p;
         if (d >= 0 && d < n) r[p*8 +: 8] = {4'h3, dg[d]};
         if ((rep == 3'h0 && p == 0) || (rep == 3'h2 && p == n - 1))
            r[p*8 +: 8] = emb(dg[p], ng);
         if ((rep == 3'h1 && p == 0) || (rep == 3'h3 && p == n))
            r[p*8 +: 8] = ng ? 8'h2d : 8'h2b;
      end
      return r;
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic run(input logic o, input int sl, input int dl,
      input logic [2:0] sr, input logic [2:0] dr, input logic u,
      input logic [255:0] im);
      op = o;
      src_len = sl[5:0];
      dst_len = dl[5:0];
      src_rep = sr;
      dst_rep = dr;
      dst_uns = u;
      img = im;
      slow = rnd() >= 32'h80000000;
      go = 1'b1;
      @(posedge sys_clk);
      #1;
      go = 1'b0;
      // fin is sampled at the edge, away from the model's own update
      do @(posedge sys_clk); while (!fin);
      #1;
   endtask
   task automatic rd_all(input logic [255:0] exp);
      for (int w = 0; w < 16; w++) begin
         dst_rd_addr = w[3:0];
         @(posedge sys_clk);
         #1;
         chk(dst_rd_data_ff, exp[w*16 +: 16]);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // cuts a hang; a full run needs about 2600 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      logic [3:0]   sg;
      logic         ng, u;
      logic [2:0]   rep;
      logic [255:0] im;
      int           p;
      seed = 32'h3de5;
      cyc = 0;
      err_total = 0;
      checked = 0;
      {rst_n, go, slow, op, dst_uns, src_rep, dst_rep} = 11'h0;
      {dst_rd_addr, src_len, dst_len} = 16'h0000;
      img = 256'h0;
      repeat (6) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 20; i++) begin
         // first two passes: widest field of nines, lone zero digit
         n = (i == 0) ? 31 : (i == 1) ? 1 : 1 + int'(rnd() % 31);
         for (int k = 0; k < 32; k++)
            dg[k] = (i == 0) ? 4'h9 : (i == 1) ? 4'h0 : 4'(rnd() % 10);
         rep = 3'(i % 5);
         sg = 4'ha + 4'(rnd() % 6);
         ng = sg[0] && sg != 4'hf;
         run(1'b1, n + 1, chlen(rep), 3'h0, rep, 1'b0, pk_img(sg));
         chk({13'h0, err_code_ff}, 16'h0000);
         chk({15'h0, res_neg_ff}, {15'h0, ng});
         rd_all(ch_img(rep, ng));
         u = rnd() >= 32'h80000000;
         // parity bits set at random must not matter
         im = ch_img(rep, ng) | ({8{rnd()}} & {32{8'h80}});
         run(1'b0, chlen(rep), n + 1, rep, 3'h0, u, im);
         chk({13'h0, err_code_ff}, 16'h0000);
         chk({15'h0, res_neg_ff}, {15'h0, ng && rep != 3'h4});
         rd_all(pk_img(u ? 4'hf : (ng && rep != 3'h4) ? 4'hd : 4'hc));
      end
      n = 8;
      // top digit cannot fit a seven-byte field: overflow
      dg[7] = 4'h5;
      run(1'b1, 9, 7, 3'h0, 3'h4, 1'b0, pk_img(4'hc));
      chk({13'h0, err_code_ff}, 16'h0003);
      chk({10'h0, err_pos_ff}, 16'h0008);
      p = 1 + int'(rnd() % 8);
      im = pk_img(4'hc);
      im[p*4 +: 4] = 4'ha + 4'(rnd() % 6);
      run(1'b1, 9, 8, 3'h0, 3'h4, 1'b0, im);
      chk({13'h0, err_code_ff}, 16'h0002);
      chk({10'h0, err_pos_ff}, 16'(p));
      im = ch_img(3'h4, 1'b0);
      im[(p-1)*8 +: 4] = 4'hb;
      run(1'b0, 8, 9, 3'h4, 3'h0, 1'b0, im);
      chk({13'h0, err_code_ff}, 16'h0002);
      chk({10'h0, err_pos_ff}, 16'(p - 1));
      run(1'b1, 33, 5, 3'h0, 3'h0, 1'b0, im);
      chk({13'h0, err_code_ff}, 16'h0004);
      rd_all(256'h0);
      run(1'b0, 5, 5, 3'h5, 3'h0, 1'b0, im);
      chk({13'h0, err_code_ff}, 16'h0004);
      stop_test();
   end
endmodule // dofc_codec_bench

bind dofc_codec dofc_codec_props i_dofc_codec_props (.sys_clk(sys_clk),
   .rst_n(rst_n), .start(start), .op(op), .src_len(src_len),
   .dst_len(dst_len), .src_rep(src_rep), .dst_rep(dst_rep),
   .busy_ff(busy_ff), .done_ff(done_ff), .err_code_ff(err_code_ff),
   .res_neg_ff(res_neg_ff));
`default_nettype wire
